// ==== logic/power_stage_control_defines.svh ====
// Offsets, reset values and timing counts of the power stage control registers.
`ifndef POWER_STAGE_CONTROL_DEFINES_SVH
`define POWER_STAGE_CONTROL_DEFINES_SVH
`define ADDR_SOFT_RAMP_PERIOD 8'h1a
`define ADDR_OSCILLATOR_CALIBRATION 8'h1b
`define ADDR_FAULT_RESTART_DELAY 8'h1c
`define ADDR_CHANNEL_SOURCE_ROUTING 8'h20
`define RST_SOFT_RAMP_PERIOD 5'h0f
`define RST_FAULT_RESTART_DELAY 4'h2
`define RST_CHANNEL_SOURCE_ROUTING 32'h0089_7772
`define ROUTING_KEEP_MASK 32'h00ff_0000
`define CLK_MHZ 40
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TRIM_CYCLES 6'h3f
`define SRC_LEFT_SLOT 3'h0
`define SRC_RIGHT_SLOT 3'h1
`define SRC_ZERO 3'h6
`endif

// ==== logic/power_stage_control_pkg.sv ====
// Types shared by the power stage control register bank.
package power_stage_control_pkg;
	typedef enum logic [1:0] {RAMP_IDLE, RAMP_RUN} ramp_state_e;
	typedef enum logic [1:0] {FAULT_RUN, FAULT_WAIT} fault_state_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic pdn_s1;
		logic pdn_s2;
		logic pdn_q;
		logic shut_q;
		logic [11:0] tick_cnt;
		logic tick;
		logic [4:0] ramp_code;
		ramp_state_e ramp_st;
		logic [17:0] ramp_cnt;
		logic ramp_active;
		logic trim_sel_n;
		logic trim_busy;
		logic trim_done;
		logic trim_en;
		logic [5:0] trim_cnt;
		logic [3:0] fault_code;
		logic fault_locked;
		fault_state_e fault_st;
		logic [13:0] fault_cnt;
		logic stage_reset;
		logic restart;
		logic [31:0] routing;
		logic [31:0] rdata;
		logic rd_valid;
	} bank_s;
endpackage

// ==== logic/power_stage_control_regs.sv ====
// Control register bank for soft ramp, oscillator trim, fault restart and channel routing.
// Functional notes
// - Ramp runs on shutdown or power-down pin change.
// - Code bits 4:3 zero skip the ramp.
// - Codes 01000-01111 select 16.5 to 125.7 ms.
// - Codes 10000-11111 select 164.6 to 13196.4 ms.
// - Ramp code resets to 125.7 ms; upper bits zero.
// - Writing zero to trim register starts factory trim.
// - Trim bit 6 reads trim done.
// - Trim bit 1 zero selects factory trim; resets one.
// - Back-end error resets stage, halts PWM.
// - Wait restart delay, then restart power stage.
// - Restart codes 0010-1001 select 299 to 1346 ms.
// - Restart codes 101x and 11xx select 1496 ms.
// - Only non-reserved restart codes are accepted.
// - Restart register writable once per reset.
// - Bits 23 and 19 pick three-state modulation.
// - Bits 22:20 pick channel 1 source.
// - Bits 18:16 pick channel 2 source; right default.
`timescale 1ns/10ps
`include "power_stage_control_defines.svh"
module power_stage_control_regs
	import power_stage_control_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire reg_req_s req_i,
	input wire logic shutdown_all_i,
	input wire logic power_down_pin_i,
	input wire logic backend_error_i,
	output logic [31:0] rdata_o,
	output logic rd_valid_o,
	output logic ramp_active_o,
	output logic trim_enable_o,
	output logic stage_reset_o,
	output logic pwm_halt_o,
	output logic restart_o,
	output logic ch1_three_state_o,
	output logic ch2_three_state_o,
	output logic [2:0] ch1_source_o,
	output logic [2:0] ch2_source_o
);
	bank_s st;
	bank_s next_st;
	logic wr_ramp;
	logic wr_trim;
	logic wr_fault;
	logic wr_route;
	logic ramp_event;

	function automatic logic [17:0] ramp_ticks(input logic [4:0] c);
		case (c)
			5'h08: ramp_ticks = 18'd165;
			5'h09: ramp_ticks = 18'd239;
			5'h0a: ramp_ticks = 18'd314;
			5'h0b: ramp_ticks = 18'd404;
			5'h0c: ramp_ticks = 18'd539;
			5'h0d: ramp_ticks = 18'd703;
			5'h0e: ramp_ticks = 18'd942;
			5'h0f: ramp_ticks = 18'd1257;
			5'h10: ramp_ticks = 18'd1646;
			5'h11: ramp_ticks = 18'd2394;
			5'h12: ramp_ticks = 18'd3142;
			5'h13: ramp_ticks = 18'd4039;
			5'h14: ramp_ticks = 18'd5386;
			5'h15: ramp_ticks = 18'd7031;
			5'h16: ramp_ticks = 18'd9425;
			5'h17: ramp_ticks = 18'd12566;
			5'h18: ramp_ticks = 18'd17281;
			5'h19: ramp_ticks = 18'd25136;
			5'h1a: ramp_ticks = 18'd32991;
			5'h1b: ramp_ticks = 18'd42417;
			5'h1c: ramp_ticks = 18'd6556;
			5'h1d: ramp_ticks = 18'd73837;
			5'h1e: ramp_ticks = 18'd98973;
			5'h1f: ramp_ticks = 18'd131964;
			default: ramp_ticks = 18'd0;
		endcase
	endfunction

	function automatic logic [13:0] fault_ticks(input logic [3:0] c);
		case (c)
			4'h2: fault_ticks = 14'd2990;
			4'h3: fault_ticks = 14'd4490;
			4'h4: fault_ticks = 14'd5980;
			4'h5: fault_ticks = 14'd7480;
			4'h6: fault_ticks = 14'd8980;
			4'h7: fault_ticks = 14'd10470;
			4'h8: fault_ticks = 14'd11970;
			4'h9: fault_ticks = 14'd13460;
			default: fault_ticks = 14'd14960;
		endcase
	endfunction

	function automatic logic src_ok(input logic [2:0] s);
		src_ok = (s == `SRC_LEFT_SLOT) || (s == `SRC_RIGHT_SLOT) || (s == `SRC_ZERO);
	endfunction

	assign wr_ramp = req_i.wr && (req_i.addr == `ADDR_SOFT_RAMP_PERIOD);
	assign wr_trim = req_i.wr && (req_i.addr == `ADDR_OSCILLATOR_CALIBRATION);
	assign wr_fault = req_i.wr && (req_i.addr == `ADDR_FAULT_RESTART_DELAY);
	assign wr_route = req_i.wr && (req_i.addr == `ADDR_CHANNEL_SOURCE_ROUTING);
	assign ramp_event = (st.shut_q != shutdown_all_i) || (st.pdn_q != st.pdn_s2);

	always_comb begin
		next_st = st;
		next_st.pdn_s1 = power_down_pin_i;
		next_st.pdn_s2 = st.pdn_s1;
		next_st.pdn_q = st.pdn_s2;
		next_st.shut_q = shutdown_all_i;
		next_st.restart = 1'b0;
		next_st.rd_valid = req_i.rd;
		next_st.tick = 1'b0;
		next_st.tick_cnt = st.tick_cnt + 12'h001;
		if (st.tick_cnt == 12'(TICK_CYCLES - 1)) begin
			next_st.tick_cnt = 12'h000;
			next_st.tick = 1'b1;
		end
		if (wr_ramp) begin
			next_st.ramp_code = req_i.wdata[4:0];
		end
		case (st.ramp_st)
			RAMP_IDLE: begin
				if (ramp_event && (st.ramp_code[4:3] != 2'h0)) begin
					next_st.ramp_st = RAMP_RUN;
					next_st.ramp_cnt = ramp_ticks(st.ramp_code);
					next_st.ramp_active = 1'b1;
				end
			end
			RAMP_RUN: begin
				if (ramp_event && (st.ramp_code[4:3] != 2'h0)) begin
					next_st.ramp_cnt = ramp_ticks(st.ramp_code);
				end else if (st.tick) begin
					if (st.ramp_cnt <= 18'd1) begin
						next_st.ramp_st = RAMP_IDLE;
						next_st.ramp_active = 1'b0;
						next_st.ramp_cnt = 18'd0;
					end else begin
						next_st.ramp_cnt = st.ramp_cnt - 18'd1;
					end
				end
			end
			default: begin
				next_st.ramp_st = RAMP_IDLE;
				next_st.ramp_active = 1'b0;
			end
		endcase
		if (st.trim_busy) begin
			next_st.trim_cnt = st.trim_cnt + 6'h01;
			if (st.trim_cnt == `TRIM_CYCLES) begin
				next_st.trim_busy = 1'b0;
				next_st.trim_done = 1'b1;
			end
		end
		if (wr_trim) begin
			next_st.trim_sel_n = req_i.wdata[1];
			if (req_i.wdata[7:0] == 8'h00) begin
				next_st.trim_busy = 1'b1;
				next_st.trim_done = 1'b0;
				next_st.trim_cnt = 6'h00;
			end
		end
		if (wr_fault && !st.fault_locked && (req_i.wdata[7:4] == 4'h0)
				&& (req_i.wdata[3:1] != 3'h0)) begin
			next_st.fault_code = req_i.wdata[3:0];
			next_st.fault_locked = 1'b1;
		end
		case (st.fault_st)
			FAULT_RUN: begin
				if (backend_error_i) begin
					next_st.fault_st = FAULT_WAIT;
					next_st.stage_reset = 1'b1;
					next_st.fault_cnt = fault_ticks(st.fault_code);
				end
			end
			FAULT_WAIT: begin
				if (st.tick) begin
					if (st.fault_cnt <= 14'd1) begin
						next_st.fault_st = FAULT_RUN;
						next_st.stage_reset = 1'b0;
						next_st.restart = 1'b1;
						next_st.fault_cnt = 14'd0;
					end else begin
						next_st.fault_cnt = st.fault_cnt - 14'd1;
					end
				end
			end
			default: begin
				next_st.fault_st = FAULT_RUN;
				next_st.stage_reset = 1'b0;
			end
		endcase
		if (wr_route) begin
			next_st.routing[23] = req_i.wdata[23];
			next_st.routing[19] = req_i.wdata[19];
			if (src_ok(req_i.wdata[22:20])) begin
				next_st.routing[22:20] = req_i.wdata[22:20];
			end
			if (src_ok(req_i.wdata[18:16])) begin
				next_st.routing[18:16] = req_i.wdata[18:16];
			end
		end
		next_st.trim_en = next_st.trim_done & ~next_st.trim_sel_n;
		next_st.rdata = 32'h0000_0000;
		if (req_i.rd) begin
			case (req_i.addr)
				`ADDR_SOFT_RAMP_PERIOD: next_st.rdata = {27'h0, st.ramp_code};
				`ADDR_OSCILLATOR_CALIBRATION: begin
					next_st.rdata = {24'h0, 1'b1, st.trim_done, 4'h0, st.trim_sel_n, 1'b0};
				end
				`ADDR_FAULT_RESTART_DELAY: next_st.rdata = {28'h0, st.fault_code};
				`ADDR_CHANNEL_SOURCE_ROUTING: next_st.rdata = st.routing;
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
		if (reset_i) begin
			next_st = '0;
			next_st.ramp_st = RAMP_IDLE;
			next_st.fault_st = FAULT_RUN;
			next_st.ramp_code = `RST_SOFT_RAMP_PERIOD;
			next_st.trim_sel_n = 1'b1;
			next_st.fault_code = `RST_FAULT_RESTART_DELAY;
			next_st.routing = `RST_CHANNEL_SOURCE_ROUTING;
		end
	end

	always_ff @(posedge mclk_i) begin
		st <= next_st;
	end

	always_comb begin
		rdata_o = st.rdata;
		rd_valid_o = st.rd_valid;
		ramp_active_o = st.ramp_active;
		trim_enable_o = st.trim_en;
		stage_reset_o = st.stage_reset;
		pwm_halt_o = st.stage_reset;
		restart_o = st.restart;
		ch1_three_state_o = st.routing[23];
		ch2_three_state_o = st.routing[19];
		ch1_source_o = st.routing[22:20];
		ch2_source_o = st.routing[18:16];
	end

	AST_FAULT_HALT: assert property (@(posedge mclk_i) disable iff (reset_i)
		(st.fault_st == FAULT_RUN && backend_error_i) |=> (stage_reset_o && pwm_halt_o))
		else $error("Back-end error did not halt the power stage.");
	AST_FAULT_RESTART: assert property (@(posedge mclk_i) disable iff (reset_i)
		$fell(stage_reset_o) |-> (restart_o && $past(st.tick) && $past(st.fault_cnt) <= 14'd1))
		else $error("Power stage restarted before the delay ran out.");
	AST_FAULT_LOCK: assert property (@(posedge mclk_i) disable iff (reset_i)
		$past(st.fault_locked) |-> $stable(st.fault_code))
		else $error("Locked restart delay changed.");
	AST_FAULT_RESERVED: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_fault && req_i.wdata[3:1] == 3'h0) |=> $stable(st.fault_code) && $stable(st.fault_locked))
		else $error("Reserved restart code was accepted.");
	AST_FAULT_LOAD: assert property (@(posedge mclk_i) disable iff (reset_i)
		(st.fault_st == FAULT_RUN && backend_error_i && st.fault_code[3] && |st.fault_code[2:1])
		|=> st.fault_cnt == 14'd14960)
		else $error("Long restart code did not give the longest delay.");
	AST_FAULT_CODE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(st.fault_st == FAULT_RUN && backend_error_i && st.fault_code == 4'h3)
		|=> st.fault_cnt == 14'd4490)
		else $error("Restart delay code three loaded the wrong count.");
	AST_RAMP_SKIP: assert property (@(posedge mclk_i) disable iff (reset_i)
		(st.ramp_st == RAMP_IDLE && st.ramp_code[4:3] == 2'h0) |=> !ramp_active_o)
		else $error("Ramp started while disabled.");
	AST_RAMP_START: assert property (@(posedge mclk_i) disable iff (reset_i)
		(st.ramp_st == RAMP_IDLE && $changed(shutdown_all_i) && st.ramp_code == 5'h08)
		|=> (ramp_active_o && st.ramp_cnt == 18'd165))
		else $error("Shutdown change did not start the ramp.");
	AST_TRIM_DONE: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_trim && req_i.wdata[7:0] == 8'h00) |=> !st.trim_done ##[64:66] st.trim_done)
		else $error("Trim did not complete in time.");
	AST_TRIM_READ: assert property (@(posedge mclk_i) disable iff (reset_i)
		(req_i.rd && req_i.addr == `ADDR_OSCILLATOR_CALIBRATION)
		|=> (rd_valid_o && rdata_o[6] == $past(st.trim_done) && rdata_o[1] == $past(st.trim_sel_n)))
		else $error("Trim register read wrong.");
	AST_RESET_VALUES: assert property (@(posedge mclk_i)
		reset_i |=> (st.ramp_code == 5'h0f && st.trim_sel_n && ch2_source_o == 3'h1))
		else $error("Reset values wrong.");
	AST_ROUTE_MODE: assert property (@(posedge mclk_i) disable iff (reset_i)
		wr_route |=> (ch1_three_state_o == $past(req_i.wdata[23]) &&
			ch2_three_state_o == $past(req_i.wdata[19])))
		else $error("Modulation scheme not taken.");
	AST_ROUTE_SRC: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_route && req_i.wdata[22:20] == 3'h2) |=> $stable(ch1_source_o))
		else $error("Reserved source code accepted.");
	AST_ROUTE_SRC2: assert property (@(posedge mclk_i) disable iff (reset_i)
		(wr_route && !src_ok(req_i.wdata[18:16])) |=> $stable(ch2_source_o))
		else $error("Reserved channel 2 source code accepted.");
	COV_FAULT: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(restart_o));
	COV_RAMP: cover property (@(posedge mclk_i) disable iff (reset_i) $fell(ramp_active_o));
	COV_TRIM: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(st.trim_done));
	COV_LOCK: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(st.fault_locked));
	COV_SKIP: cover property (@(posedge mclk_i) disable iff (reset_i)
		(ramp_event && st.ramp_code[4:3] == 2'h0));
endmodule // power_stage_control_regs

// ==== sim/host_model.sv ====
// Host model that issues register commands to the control bank.
`timescale 1ns/10ps
module host_model
	import power_stage_control_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [31:0] rdata_i,
	input wire logic rd_valid_i,
	output reg_req_s req_o
);
	initial req_o = '0;
	// One-cycle command; idle address and data lines carry the inverse of the last value, wr and rd go low.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge mclk_i);
		req_o <= '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
		@(posedge mclk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
		#1;
		rdata = rd_valid_i ? rdata_i : 32'hxxxx_xxxx;
	endtask
endmodule // host_model

// ==== sim/test_power_stage_control_regs.sv ====
// Self-checking bench for the power stage control register bank.
`timescale 1ns/10ps
`include "power_stage_control_defines.svh"
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t got %h exp %h", $time, (got), (exp)); end end
module test_power_stage_control_regs
	import power_stage_control_pkg::*;
;
	localparam int TICK = 2;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic shutdown_all = 1'b0;
	logic power_down_pin = 1'b0;
	logic backend_error = 1'b0;
	reg_req_s req;
	logic [31:0] rdata, rv, wd, route;
	logic rd_valid, ramp_active, trim_enable, stage_reset, pwm_halt, restart;
	logic ch1_ts, ch2_ts;
	logic [2:0] ch1_src, ch2_src;
	int fail_count = 0;
	int num_checks = 0;
	int n;
	logic [4:0] codes[6] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0f, 5'h10};
	int tenths[6] = '{0, 0, 165, 239, 1257, 1646};
	initial forever #12.5 mclk = ~mclk;
	power_stage_control_regs #(.TICK_CYCLES(TICK)) power_stage_control_regs_inst (
		.mclk_i(mclk), .reset_i(reset), .req_i(req), .shutdown_all_i(shutdown_all),
		.power_down_pin_i(power_down_pin), .backend_error_i(backend_error), .rdata_o(rdata),
		.rd_valid_o(rd_valid), .ramp_active_o(ramp_active), .trim_enable_o(trim_enable),
		.stage_reset_o(stage_reset), .pwm_halt_o(pwm_halt), .restart_o(restart),
		.ch1_three_state_o(ch1_ts), .ch2_three_state_o(ch2_ts), .ch1_source_o(ch1_src),
		.ch2_source_o(ch2_src));
	host_model host_model_inst (.mclk_i(mclk), .rdata_i(rdata), .rd_valid_i(rd_valid),
		.req_o(req));
	function automatic logic [31:0] route_next(logic [31:0] old, logic [31:0] w);
		route_next = old;
		route_next[23] = w[23];
		route_next[19] = w[19];
		if (w[22:20] inside {3'h0, 3'h1, 3'h6}) route_next[22:20] = w[22:20];
		if (w[18:16] inside {3'h0, 3'h1, 3'h6}) route_next[18:16] = w[18:16];
	endfunction
	function automatic logic sig(bit fault);
		return fault ? stage_reset : ramp_active;
	endfunction
	task automatic do_reset;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_model_inst.access(1'b1, a, d, rv);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		host_model_inst.access(1'b0, a, 32'h0, rv);
		`CHECK(rv, e)
	endtask
	// Counts the cycles an output stays high; in fault runs a second error lands mid-wait.
	task automatic span(input bit fault, output int cnt);
		cnt = 0;
		repeat (6) begin
			@(posedge mclk);
			backend_error <= 1'b0;
			#1;
			if (sig(fault)) break;
		end
		while (sig(fault) === 1'b1 && cnt < 70000) begin
			cnt++;
			@(posedge mclk);
			if (fault) backend_error <= (cnt == 100);
			#1;
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#(25 * 90000);
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'h0e38));
		do_reset();
		`CHECK({ch1_ts, ch2_ts, ch1_src, ch2_src}, 8'hc1)
		rd_chk(`ADDR_SOFT_RAMP_PERIOD, 32'h0f);
		rd_chk(`ADDR_OSCILLATOR_CALIBRATION, 32'h82);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h02);
		rd_chk(`ADDR_CHANNEL_SOURCE_ROUTING, 32'h0089_7772);
		rd_chk(8'h21, 32'h0);
		wr(`ADDR_OSCILLATOR_CALIBRATION, 32'h0);
		rd_chk(`ADDR_OSCILLATOR_CALIBRATION, 32'h80);
		`CHECK(trim_enable, 1'b0)
		repeat (70) @(posedge mclk);
		rd_chk(`ADDR_OSCILLATOR_CALIBRATION, 32'hc0);
		`CHECK(trim_enable, 1'b1)
		wr(`ADDR_OSCILLATOR_CALIBRATION, 32'h2);
		rd_chk(`ADDR_OSCILLATOR_CALIBRATION, 32'hc2);
		`CHECK(trim_enable, 1'b0)
		route = 32'h0089_7772;
		for (int i = 0; i < 12; i++) begin
			wd = $urandom;
			wd[31:24] = 8'h00;
			wd[15:0] = 16'h7772;
			if (i < 8) begin
				wd[22:20] = i[2:0];
				wd[18:16] = ~i[2:0];
			end
			wr(`ADDR_CHANNEL_SOURCE_ROUTING, wd);
			route = route_next(route, wd);
			rd_chk(`ADDR_CHANNEL_SOURCE_ROUTING, route);
			`CHECK({ch1_ts, ch1_src, ch2_ts, ch2_src}, route[23:16])
		end
		wr(`ADDR_CHANNEL_SOURCE_ROUTING, `RST_CHANNEL_SOURCE_ROUTING);
		`CHECK({ch1_ts, ch2_ts}, 2'b11)
		wr(`ADDR_SOFT_RAMP_PERIOD, 32'he8);
		rd_chk(`ADDR_SOFT_RAMP_PERIOD, 32'h08);
		for (int i = 0; i < 6; i++) begin
			wr(`ADDR_SOFT_RAMP_PERIOD, {27'h0, codes[i]});
			@(posedge mclk);
			if (i == 5) power_down_pin <= 1'b1;
			else shutdown_all <= ~shutdown_all;
			span(1'b0, n);
			`CHECK(n >= tenths[i] * TICK - TICK && n <= tenths[i] * TICK + TICK, 1'b1)
		end
		wr(`ADDR_FAULT_RESTART_DELAY, 32'h00);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h02);
		wr(`ADDR_FAULT_RESTART_DELAY, 32'hf3);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h02);
		wr(`ADDR_FAULT_RESTART_DELAY, 32'h03);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h03);
		wr(`ADDR_FAULT_RESTART_DELAY, 32'h05);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h03);
		@(posedge mclk);
		backend_error <= 1'b1;
		span(1'b1, n);
		`CHECK(n >= 4490 * TICK - TICK && n <= 4490 * TICK + TICK, 1'b1)
		`CHECK({restart, stage_reset, pwm_halt}, 3'b100)
		do_reset();
		rd_chk(`ADDR_CHANNEL_SOURCE_ROUTING, 32'h0089_7772);
		wr(`ADDR_FAULT_RESTART_DELAY, 32'h0b);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h0b);
		wr(`ADDR_FAULT_RESTART_DELAY, 32'h0e);
		rd_chk(`ADDR_FAULT_RESTART_DELAY, 32'h0b);
		@(posedge mclk);
		backend_error <= 1'b1;
		span(1'b1, n);
		`CHECK(n >= 14960 * TICK - TICK && n <= 14960 * TICK + TICK, 1'b1)
		`CHECK({restart, stage_reset, pwm_halt}, 3'b100)
		close_out();
	end
endmodule // test_power_stage_control_regs
